// [rtl/sfs_front_end.sv]
`timescale 1ns/100ps
module sfs_front_end #(
  parameter sfs_pkg::sfs_density_t DENSITY = sfs_pkg::DEN_4M
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        serialClk,
  input  wire logic        chipSelN,
  input  wire logic [3:0]  dataLineIn,
  output logic      [3:0]  dataLineOut,
  output logic      [3:0]  dataLineOe,
  output logic      [7:0]  deviceStatus,
  output logic             eraseStart,
  output sfs_pkg::sfs_erase_t eraseKind,
  output logic      [11:0] eraseSector,
  output logic      [8:0]  eraseBlock32,
  output logic      [7:0]  eraseBlock64
);
  import sfs_pkg::*;

  // --------------------------------------------------------------------------
  // Address helpers.
  // --------------------------------------------------------------------------
  function automatic logic [23:0] maxAddr(input sfs_density_t d);
    case (d)
      DEN_256K: maxAddr = MAX_ADDR_256K;
      DEN_512K: maxAddr = MAX_ADDR_512K;
      DEN_1M:   maxAddr = MAX_ADDR_1M;
      DEN_2M:   maxAddr = MAX_ADDR_2M;
      default:  maxAddr = MAX_ADDR_4M;
    endcase
  endfunction : maxAddr

  localparam logic SMALL_PART = (DENSITY == DEN_256K) || (DENSITY == DEN_512K);

  // --------------------------------------------------------------------------
  // Pin synchronisers and serial clock edges.
  // --------------------------------------------------------------------------
  logic [5:0] pinSync;
  logic       sckS, csNS, io0S, wpNS, holdNS;
  logic       sckPrev_q;
  logic       sckRise, sckFall, csActive, qe, pause;

  sfs_sync #(.W(6)) uSync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({serialClk, ~chipSelN, dataLineIn}),
    .syncOut (pinSync)
  );

  assign sckS     = pinSync[5];
  // Select is synchronised inverted so that reset leaves the frame deselected.
  assign csNS     = ~pinSync[4];
  assign io0S     = pinSync[0];
  assign wpNS     = pinSync[2];
  assign holdNS   = pinSync[3];
  // Both modes share one edge rule; only the parked level differs.
  assign sckRise  = sckS & ~sckPrev_q;
  assign sckFall  = ~sckS & sckPrev_q;
  assign csActive = ~csNS;

  // --------------------------------------------------------------------------
  // Frame state.
  // --------------------------------------------------------------------------
  sfs_state_t         state_q, state_d;
  logic [4:0]         bitCnt_q, bitCnt_d;
  logic [23:0]        shift_q, shift_d;
  logic [2:0]         rdIdx_q, rdIdx_d;
  sfs_erase_t         kind_q, kind_d;
  logic [5:0]         nv_q, nv_d;
  logic               wel_q, wel_d;
  logic [BUSY_W-1:0]  busyCnt_q, busyCnt_d;
  logic [3:0]         out_q, out_d, oe_q, oe_d;
  logic [7:0]         status_q, status_d;
  logic               ers_q, ers_d;
  sfs_erase_t         ersKind_q, ersKind_d;
  logic [23:0]        ersAddr_q, ersAddr_d;
  logic [7:0]         opcode, liveStatus;
  logic               busy, swLocked, stCommit, erCommit;

  assign qe         = nv_q[NV_QE_IDX];
  // The pause function only exists while the pin is not a data line.
  assign pause      = ~qe & ~holdNS;
  assign busy       = (busyCnt_q != BUSY_NONE);
  assign liveStatus = {nv_q, wel_q, busy};
  assign opcode     = {shift_q[6:0], io0S};
  // Hardware lock on status writes.
  assign swLocked   = nv_q[NV_SWD_IDX] & ~wpNS & ~qe;
  assign stCommit   = ~csActive & (state_q == ST_WDATA) & (bitCnt_q == DATA_BITS);
  assign erCommit   = ~csActive & (state_q == ST_ADDR) & (bitCnt_q == ADDR_BITS);

  always_comb begin
    state_d   = state_q;
    bitCnt_d  = bitCnt_q;
    shift_d   = shift_q;
    rdIdx_d   = rdIdx_q;
    kind_d    = kind_q;
    nv_d      = nv_q;
    wel_d     = wel_q;
    busyCnt_d = busy ? busyCnt_q - BUSY_LAST : busyCnt_q;
    out_d     = out_q;
    oe_d      = '0;
    ers_d     = 1'b0;
    ersKind_d = ersKind_q;
    ersAddr_d = ersAddr_q;
    if (busyCnt_q == BUSY_LAST) begin
      wel_d = 1'b0;
    end
    if (!csActive) begin
      state_d  = ST_IDLE;
      bitCnt_d = '0;
      if (stCommit && wel_q && !busy && !swLocked) begin
        nv_d      = shift_q[7:2];
        busyCnt_d = STATUS_WRITE_CYCLES;
      end else if (erCommit && wel_q && !busy) begin
        ers_d     = 1'b1;
        ersAddr_d = shift_q & maxAddr(DENSITY);
        ersKind_d = (SMALL_PART && kind_q == KIND_BLOCK64) ? KIND_BLOCK32 : kind_q;
        busyCnt_d = ERASE_CYCLES;
      end
    end else if (pause) begin
      oe_d = '0;
    end else begin
      if (state_q == ST_IDLE) begin
        state_d  = ST_OPCODE;
        bitCnt_d = '0;
      end
      if (sckRise && state_q != ST_IDLE && state_q != ST_READ) begin
        shift_d  = {shift_q[22:0], io0S};
        bitCnt_d = (state_q == ST_IGNORE) ? bitCnt_q : bitCnt_q + 5'h01;
      end
      if (sckRise && state_q == ST_OPCODE && bitCnt_q == OPCODE_LAST) begin
        bitCnt_d = '0;
        rdIdx_d  = '0;
        state_d  = ST_IGNORE;
        if (opcode == CMD_READ_STATUS) begin
          state_d = ST_READ;
        end else if (opcode == CMD_WRITE_DISABLE && !busy) begin
          wel_d = 1'b0;
        end else if (opcode == CMD_WRITE_ENABLE && !busy) begin
          wel_d = 1'b1;
        end else if (opcode == CMD_WRITE_STATUS) begin
          state_d = ST_WDATA;
        end else if (opcode == CMD_SECTOR_ERASE) begin
          state_d = ST_ADDR;
          kind_d  = KIND_SECTOR;
        end else if (opcode == CMD_BLOCK32_ERASE) begin
          state_d = ST_ADDR;
          kind_d  = KIND_BLOCK32;
        end else if (opcode == CMD_BLOCK64_ERASE) begin
          state_d = ST_ADDR;
          kind_d  = KIND_BLOCK64;
        end
      end
      if ((state_q == ST_ADDR && bitCnt_q == ADDR_BITS) ||
          (state_q == ST_WDATA && bitCnt_q == DATA_BITS)) begin
        bitCnt_d = bitCnt_q;
        shift_d  = shift_q;
      end
      if (state_q == ST_READ) begin
        oe_d[1] = 1'b1;
        if (sckFall) begin
          out_d[1] = liveStatus[3'h7 - rdIdx_q];
          rdIdx_d  = rdIdx_q + 3'h1;
        end
      end
    end
    status_d = liveStatus;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckPrev_q <= 1'b0;
      state_q   <= ST_IDLE;
      bitCnt_q  <= '0;
      shift_q   <= '0;
      rdIdx_q   <= '0;
      kind_q    <= KIND_SECTOR;
      nv_q      <= NV_RESET;
      wel_q     <= 1'b0;
      busyCnt_q <= BUSY_NONE;
      out_q     <= '0;
      oe_q      <= '0;
      status_q  <= STATUS_RESET;
      ers_q     <= 1'b0;
      ersKind_q <= KIND_SECTOR;
      ersAddr_q <= '0;
    end else begin
      sckPrev_q <= sckS;
      state_q   <= state_d;
      bitCnt_q  <= bitCnt_d;
      shift_q   <= shift_d;
      rdIdx_q   <= rdIdx_d;
      kind_q    <= kind_d;
      nv_q      <= nv_d;
      wel_q     <= wel_d;
      busyCnt_q <= busyCnt_d;
      out_q     <= out_d;
      oe_q      <= oe_d;
      status_q  <= status_d;
      ers_q     <= ers_d;
      ersKind_q <= ersKind_d;
      ersAddr_q <= ersAddr_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------------
  assign dataLineOut  = out_q;
  assign dataLineOe   = oe_q;
  assign deviceStatus = status_q;
  assign eraseStart   = ers_q;
  assign eraseKind    = ersKind_q;
  assign eraseSector  = ersAddr_q[ADDR_MSB:SECTOR_LSB];
  assign eraseBlock32 = ersAddr_q[ADDR_MSB:BLOCK32_LSB];
  assign eraseBlock64 = ersAddr_q[ADDR_MSB:BLOCK64_LSB];

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  a_rise_capture: assert property (@(posedge clk) disable iff (rst)
    (sckRise && csActive && !pause && state_q == ST_OPCODE) |=> shift_q[0] == $past(io0S))
    else $error("Input bit not captured on rising edge.");

  a_fall_launch: assert property (@(posedge clk) disable iff (rst)
    $changed(out_q[1]) |-> $past(sckFall) && $past(state_q) == ST_READ)
    else $error("Output bit changed away from a falling edge.");

  a_reset_zero: assert property (@(posedge clk)
    (!rst && $past(rst)) |-> status_q == STATUS_RESET)
    else $error("Status not zero after reset.");

  a_busy_flag: assert property (@(posedge clk) disable iff (rst)
    ##1 status_q[ST_BUSY_BIT] == ($past(busyCnt_q) != BUSY_NONE))
    else $error("Busy flag does not follow the busy cycle.");

  a_status_layout: assert property (@(posedge clk) disable iff (rst)
    ##1 status_q[ST_SWD_BIT:ST_WEL_BIT] == {$past(nv_q), $past(wel_q)})
    else $error("Status bit layout wrong.");

  a_wel_autoclear: assert property (@(posedge clk) disable iff (rst)
    (busyCnt_q == BUSY_LAST) |=> !wel_q ##1 !status_q[ST_WEL_BIT])
    else $error("Write enable latch not cleared after operation.");

  a_locked_ignore: assert property (@(posedge clk) disable iff (rst)
    (stCommit && swLocked) |=> $stable(nv_q) && (busyCnt_q == $past(busyCnt_q) - BUSY_LAST
      || $past(busyCnt_q) == BUSY_NONE && busyCnt_q == BUSY_NONE))
    else $error("Locked status write was taken.");

  a_pause_freeze: assert property (@(posedge clk) disable iff (rst)
    (csActive && pause && state_q != ST_IDLE) |=> $stable(shift_q) && oe_q == 4'h0)
    else $error("Pause did not freeze the frame.");

  a_quad_nopause: assert property (@(posedge clk) disable iff (rst)
    (qe && csActive && !holdNS && sckRise && state_q == ST_OPCODE) |=> bitCnt_q != $past(bitCnt_q))
    else $error("Pause acted while quad enable set.");

  a_block_index: assert property (@(posedge clk) disable iff (rst)
    eraseStart |-> eraseBlock32 == eraseSector[11:3] && eraseBlock64 == eraseSector[11:4])
    else $error("Block index does not match sector index.");

  a_small_no64: assert property (@(posedge clk) disable iff (rst)
    (eraseStart && SMALL_PART) |-> eraseKind != KIND_BLOCK64)
    else $error("64 KB erase issued on a small part.");

  a_addr_range: assert property (@(posedge clk) disable iff (rst)
    eraseStart |-> (ersAddr_q & ~maxAddr(DENSITY)) == 24'h000000)
    else $error("Erase address beyond the part.");

  c_read_status:  cover property (@(posedge clk) disable iff (rst) oe_q[1] && sckFall);
  c_status_write: cover property (@(posedge clk) disable iff (rst) stCommit && wel_q && !swLocked);
  c_erase_start:  cover property (@(posedge clk) disable iff (rst) eraseStart);
  c_pause_seen:   cover property (@(posedge clk) disable iff (rst) csActive && pause);

endmodule : sfs_front_end

// [rtl/sfs_pkg.sv]
// ----------------------------------------------------------------------------
// Overview of operation
// - The front end works in clock mode 0 and mode 3 and the bench master uses both, mode 0 first and then mode 3.
// - Every instruction, address and data bit is captured on the rising serial clock edge.
// - Every outgoing status bit is launched from the falling serial clock edge.
// - In multi-I/O use data lines 0 and 1 and the protect and pause pins become data lines.
// - The two smallest densities have 4 KB sectors and 32 KB blocks and no 64 KB blocks.
// - The larger densities group 8 sectors per 32 KB block and 16 per 64 KB block.
// - Sectors are 0x1000 bytes from address zero up to the density's highest address.
// - The device has a status and a function register and status bits set protection.
// - Status bits from 7 down to 0 are write disable, quad enable, protect 3..0, latch, busy.
// - Every status bit reads zero in its default state.
// - The busy flag reads one while a program, erase or register write cycle runs.
// - The write-enable latch clears itself when a write, program or erase completes.
// - With quad enable set the protect and pause pins lose their functions and carry data.
// - With write disable set and the protect pin low a status write is ignored.
// ----------------------------------------------------------------------------
package sfs_pkg;

  // --------------------------------------------------------------------------
  // Densities and address limits.
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    DEN_256K = 3'h0,
    DEN_512K = 3'h1,
    DEN_1M   = 3'h2,
    DEN_2M   = 3'h3,
    DEN_4M   = 3'h4
  } sfs_density_t;

  localparam logic [23:0] MAX_ADDR_256K = 24'h007FFF;
  localparam logic [23:0] MAX_ADDR_512K = 24'h00FFFF;
  localparam logic [23:0] MAX_ADDR_1M   = 24'h01FFFF;
  localparam logic [23:0] MAX_ADDR_2M   = 24'h03FFFF;
  localparam logic [23:0] MAX_ADDR_4M   = 24'h07FFFF;

  localparam int SECTOR_LSB  = 12;
  localparam int BLOCK32_LSB = 15;
  localparam int BLOCK64_LSB = 16;
  localparam int ADDR_MSB    = 23;

  // --------------------------------------------------------------------------
  // Status register layout.
  // --------------------------------------------------------------------------
  localparam int          ST_BUSY_BIT  = 0;
  localparam int          ST_WEL_BIT   = 1;
  localparam int          ST_PROT_LSB  = 2;
  localparam int          ST_QE_BIT    = 6;
  localparam int          ST_SWD_BIT   = 7;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [5:0]  NV_RESET     = 6'h00;
  localparam int          NV_QE_IDX    = 4;
  localparam int          NV_SWD_IDX   = 5;

  // --------------------------------------------------------------------------
  // Commands and frame lengths.
  // --------------------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLOCK64_ERASE = 8'hD8;

  localparam logic [4:0] OPCODE_LAST = 5'h07;
  localparam logic [4:0] DATA_BITS   = 5'h08;
  localparam logic [4:0] ADDR_BITS   = 5'h18;

  typedef enum logic [1:0] {
    KIND_SECTOR  = 2'h0,
    KIND_BLOCK32 = 2'h1,
    KIND_BLOCK64 = 2'h2
  } sfs_erase_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR   = 3'h2,
    ST_WDATA  = 3'h3,
    ST_READ   = 3'h4,
    ST_IGNORE = 3'h5
  } sfs_state_t;

  // --------------------------------------------------------------------------
  // Busy durations in clock cycles.
  // --------------------------------------------------------------------------
  localparam int          BUSY_W             = 16;
  localparam logic [15:0] STATUS_WRITE_CYCLES = 16'h0100;
  localparam logic [15:0] ERASE_CYCLES        = 16'h0400;
  localparam logic [15:0] BUSY_LAST           = 16'h0001;
  localparam logic [15:0] BUSY_NONE           = 16'h0000;

endpackage : sfs_pkg

// [rtl/sfs_sync.sv]
`timescale 1ns/100ps
module sfs_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule : sfs_sync

// [tb/sfs_spi_master.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Serial master model that frames commands and samples returned bits.
// ----------------------------------------------------------------------------
module sfs_spi_master (
  output logic      sck,
  output logic      csN,
  output logic      mosi,
  input  wire logic miso
);
  logic mode3;

  initial begin
    mode3 = 1'b0;
    sck   = 1'b0;
    csN   = 1'b1;
    mosi  = 1'b0;
  end

  task automatic setMode(input logic md);
    mode3 = md;
    sck   = md;
    #200;
  endtask : setMode

  // Sends nb bits of tx MSB first and keeps the last eight bits seen.
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [7:0] rx);
    sck = mode3;
    csN = 1'b0;
    #100;
    for (int i = nb - 1; i >= 0; i--) begin
      sck  = 1'b0;
      mosi = tx[i];
      #80;
      sck = 1'b1;
      #78;
      rx = {rx[6:0], miso};
      #2;
    end
    sck = mode3;
    #60;
    csN  = 1'b1;
    mosi = ~mosi;
    #100;
  endtask : xfer
endmodule : sfs_spi_master

// [tb/sfs_front_end_tb.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Self-checking bench for the serial flash front end.
// ----------------------------------------------------------------------------
module sfs_front_end_tb;
  import sfs_pkg::*;

  logic        clk;
  logic        rst;
  logic        wpN;
  logic        pauseN;
  logic        sdoLast;
  logic [7:0]  rx;
  logic [7:0]  d;
  logic [23:0] a;
  int          seed;
  int          c;
  int          errors = 0;
  int          comparisons = 0;
  int          busyRun = 0;
  int          busyLen = 0;
  logic [30:0] q4[$];
  logic [30:0] q5[$];
  logic [30:0] expRd[$];
  event        rdEv;
  wire         sck;
  wire         csN;
  wire         mosi;
  wire         miso;
  wire         st4;
  wire         st5;
  wire [3:0]   dOut;
  wire [3:0]   dOe;
  wire [7:0]   stat;
  wire [30:0]  ers4;
  wire [30:0]  ers5;
  wire [3:0]   pins = {pauseN, wpN, miso, mosi};

  assign miso = dOe[1] ? dOut[1] : ~sdoLast;

  sfs_spi_master m (
    .sck  (sck),
    .csN  (csN),
    .mosi (mosi),
    .miso (miso)
  );

  sfs_front_end uut (
    .clk          (clk),
    .rst          (rst),
    .serialClk    (sck),
    .chipSelN     (csN),
    .dataLineIn   (pins),
    .dataLineOut  (dOut),
    .dataLineOe   (dOe),
    .deviceStatus (stat),
    .eraseStart   (st4),
    .eraseKind    (ers4[30:29]),
    .eraseSector  (ers4[28:17]),
    .eraseBlock32 (ers4[16:8]),
    .eraseBlock64 (ers4[7:0])
  );

  sfs_front_end #(.DENSITY(DEN_512K)) uut2 (
    .clk          (clk),
    .rst          (rst),
    .serialClk    (sck),
    .chipSelN     (csN),
    .dataLineIn   (pins),
    .dataLineOut  (),
    .dataLineOe   (),
    .deviceStatus (),
    .eraseStart   (st5),
    .eraseKind    (ers5[30:29]),
    .eraseSector  (ers5[28:17]),
    .eraseBlock32 (ers5[16:8]),
    .eraseBlock64 (ers5[7:0])
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic popChk(input string nm, ref logic [30:0] q[$], input logic [30:0] g);
    if (q.size() == 0) chk(nm, {1'b1, 31'h0}, {1'b0, g});
    else chk(nm, {1'b0, q.pop_front()}, {1'b0, g});
  endtask : popChk

  function automatic logic [30:0] ersExp(logic [1:0] k, logic [23:0] ad, logic [23:0] mx);
    logic [23:0] w;
    w = ad & mx;
    return {k, w[23:12], w[23:15], w[23:16]};
  endfunction : ersExp

  task automatic frame(input logic [31:0] tx, input int nb);
    @(posedge clk);
    #2;
    m.xfer(tx, nb, rx);
  endtask : frame

  task automatic rdStat(input logic [7:0] e);
    expRd.push_back({23'h0, e});
    frame({16'h0, CMD_READ_STATUS, 8'h00}, 16);
    ->rdEv;
  endtask : rdStat

  task automatic stChk(input logic [7:0] e);
    repeat (6) @(posedge clk);
    chk("status", {24'h0, e}, {24'h0, stat});
  endtask : stChk

  task automatic idleWait(output int n);
    n = 0;
    while (stat[0] !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (stat[0] === 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    #1;
    n = busyLen;
    chk("idle", 32'h0, {31'h0, stat[0]});
  endtask : idleWait

  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    if (dOe[1] === 1'b1) sdoLast <= dOut[1];
    if (st4 === 1'b1) popChk("erase 4M", q4, ers4);
    if (st5 === 1'b1) popChk("erase 512K", q5, ers5);
  end

  always @(rdEv) popChk("status read", expRd, {23'h0, rx});

  always @(posedge clk) begin
    if (stat[0] === 1'b1) begin
      busyRun <= busyRun + 1;
    end else if (busyRun != 0) begin
      busyLen <= busyRun;
      busyRun <= 0;
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #1000000;
    errors++;
    print_verdict();
  end

  initial begin
    seed    = 97;
    rst     = 1'b1;
    wpN     = 1'b1;
    pauseN  = 1'b1;
    sdoLast = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    rst = 1'b0;
    stChk(8'h00);
    rdStat(8'h00);
    fork
      frame({24'h0, CMD_WRITE_ENABLE}, 8);
      begin
        repeat (20) @(posedge clk);
        #2;
        pauseN = 1'b0;
      end
    join
    pauseN = 1'b1;
    stChk(8'h00);
    frame({24'h0, CMD_WRITE_ENABLE}, 8);
    stChk(8'h02);
    rdStat(8'h02);
    frame({24'h0, CMD_WRITE_DISABLE}, 8);
    stChk(8'h00);
    frame({24'h0, CMD_WRITE_ENABLE}, 8);
    d = 8'($random(seed));
    d[7:6] = 2'b00;
    frame({16'h0, CMD_WRITE_STATUS, d}, 16);
    idleWait(c);
    chk("busy cycles", {16'h0, STATUS_WRITE_CYCLES}, 32'(c));
    stChk({d[7:2], 2'b00});
    frame({CMD_SECTOR_ERASE, 24'h000000}, 32);
    stChk({d[7:2], 2'b00});
    for (int k = 0; k < 3; k++) begin
      a = 24'($random(seed));
      frame({24'h0, CMD_WRITE_ENABLE}, 8);
      q4.push_back(ersExp(2'(k), a, MAX_ADDR_4M));
      q5.push_back(ersExp((k == 0) ? 2'h0 : 2'h1, a, MAX_ADDR_512K));
      frame({(k == 0) ? CMD_SECTOR_ERASE : (k == 1) ? CMD_BLOCK32_ERASE : CMD_BLOCK64_ERASE,
             a}, 32);
      rdStat({d[7:2], 2'b11});
      idleWait(c);
      chk("erase busy", {16'h0, ERASE_CYCLES}, 32'(c));
    end
    stChk({d[7:2], 2'b00});
    #2;
    m.setMode(1'b1);
    frame({24'h0, CMD_WRITE_ENABLE}, 8);
    frame({16'h0, CMD_WRITE_STATUS, 8'h80}, 16);
    idleWait(c);
    @(posedge clk);
    #2;
    wpN = 1'b0;
    frame({24'h0, CMD_WRITE_ENABLE}, 8);
    frame({16'h0, CMD_WRITE_STATUS, 8'h3C}, 16);
    stChk(8'h82);
    rdStat(8'h82);
    @(posedge clk);
    #2;
    wpN = 1'b1;
    frame({16'h0, CMD_WRITE_STATUS, 8'h40}, 16);
    idleWait(c);
    stChk(8'h40);
    @(posedge clk);
    #2;
    wpN    = 1'b0;
    pauseN = 1'b0;
    rdStat(8'h40);
    print_verdict();
  end
endmodule : sfs_front_end_tb
